//--- hdl/edge_event_if.sv
// Carrier from an input synchroniser to the timer core.
// Assumes producer and consumer share clk_sys.
`timescale 1ns/1ns
interface edge_event_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : edge_event_if

//--- hdl/edge_sync.sv
// Two-flop synchroniser with a rising-edge detector for a capture pin.
// Assumes pin_in is asynchronous to clk_sys.
`timescale 1ns/1ns
module edge_sync
  import tcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic arm,
  edge_event_if.src ev
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Only sync_q reads meta_q; the detector looks at later stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are dropped while disarmed, so a stale level cannot trigger
  assign ev.level = sync_q;
  assign ev.rise = arm & sync_q & ~prev_q;
endmodule : edge_sync

//--- hdl/tcc_pkg.sv
// Shared constants for the 16-bit capture/compare timer.
// Assumes a single system clock; no software bus reaches these values.
package tcc_pkg;
  localparam int COUNT_W = 16;
  localparam int CTRL_W = 4;
  localparam int MODE_HI_POS = 3;
  localparam int MODE_LO_POS = 2;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CC_RESET = 16'h0000;
  localparam int PRESCALE_DEF = 4;
  localparam logic PIN_FUNC_CAPTURE = 1'b0;
  localparam logic PIN_FUNC_OUTPUT = 1'b1;
endpackage : tcc_pkg

//--- hdl/timer_capture_compare_16bit.sv
// Core of the 16-bit timer with two capture/compare registers.
// Assumes control strobes come from logic on clk_sys, pins from outside.
`timescale 1ns/1ns
module timer_capture_compare_16bit
  import tcc_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_wr,
  input wire logic [CTRL_W-1:0] timer_mode_ctrl,
  input wire logic cc0_cmp_mode,
  input wire logic cc1_cmp_mode,
  input wire logic cc0_wr,
  input wire logic cc1_wr,
  input wire logic [COUNT_W-1:0] cmp_wdata,
  input wire logic cnt_rd,
  input wire logic capture_input_zero,
  input wire logic pin_func_sel,
  input wire logic shared_port_pin_in,
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe,
  output logic [COUNT_W-1:0] up_counter_value,
  output logic [COUNT_W-1:0] capcmp_reg_zero,
  output logic [COUNT_W-1:0] capcmp_reg_one,
  output logic running
);

  if (PRESCALE < 1 || PRESCALE > 65536) begin : g_bad_prescale
    $error("PRESCALE out of range");
  end

  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE - 1);

  ////////////////////////////////////////////////////////////////////////
  // Mode field and prescaler

  logic [1:0] mode_q;
  logic [PW-1:0] presc_q;
  logic tick;
  logic stop_now;
  logic [1:0] mode_wfield;
  logic pend_q;

  assign mode_wfield = {timer_mode_ctrl[MODE_HI_POS],
                        timer_mode_ctrl[MODE_LO_POS]};
  assign stop_now = mode_wr & (mode_wfield == MODE_STOP);
  assign running = (mode_q != MODE_STOP);

  // Mode write takes effect on the next edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_RESET;
    end else if (mode_wr) begin
      mode_q <= mode_wfield;
    end
  end

  // Count-clock enable; restarts from zero so each run is phase aligned
  // A long read stalls here, since only one parked tick can be held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_q <= '0;
    end else if (!running) begin
      presc_q <= '0;
    end else if (cnt_rd && pend_q && presc_q == PRESC_LAST) begin
      presc_q <= presc_q;
    end else if (presc_q == PRESC_LAST) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + PW'(1);
    end
  end

  // A second tick waits until the parked one is paid, so none is lost
  assign tick = running & (presc_q == PRESC_LAST) & ~(cnt_rd & pend_q);

  ////////////////////////////////////////////////////////////////////////
  // Counter with read hold-off

  logic [COUNT_W-1:0] cnt_q;
  logic [1:0] inc;

  // A tick arriving during a read is parked, then added after the read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (!running) begin
      pend_q <= 1'b0;
    end else if (cnt_rd) begin
      pend_q <= pend_q | tick;
    end else begin
      pend_q <= 1'b0;
    end
  end

  assign inc = {1'b0, tick} + {1'b0, pend_q};

  // Counter clears when stopped; frozen while a read is in progress
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_RESET;
    end else if (!running) begin
      cnt_q <= CNT_RESET;
    end else if (!cnt_rd) begin
      cnt_q <= cnt_q + COUNT_W'(inc);
    end
  end

  assign up_counter_value = cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Capture inputs

  edge_event_if ev0 ();
  edge_event_if ev1 ();
  logic arm1;

  // Input one only listens while the pin is in capture role
  assign arm1 = running & (pin_func_sel == PIN_FUNC_CAPTURE);

  edge_sync u_sync0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(capture_input_zero),
    .arm(running),
    .ev(ev0)
  );

  edge_sync u_sync1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(shared_port_pin_in),
    .arm(arm1),
    .ev(ev1)
  );

  ////////////////////////////////////////////////////////////////////////
  // Capture/compare registers

  logic [COUNT_W-1:0] cc0_q;
  logic [COUNT_W-1:0] cc1_q;
  logic cap0;
  logic cap1;

  // Collision with a stop write drops the capture rather than store junk
  assign cap0 = ev0.rise & ~cc0_cmp_mode & ~stop_now;
  assign cap1 = ev1.rise & ~cc1_cmp_mode & ~stop_now;

  // Only a capture or a compare-mode write replaces the held value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cc0_q <= CC_RESET;
    end else if (cc0_cmp_mode && cc0_wr) begin
      cc0_q <= cmp_wdata;
    end else if (cap0) begin
      cc0_q <= cnt_q;
    end
  end

  // A counter read has no path into this register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cc1_q <= CC_RESET;
    end else if (cc1_cmp_mode && cc1_wr) begin
      cc1_q <= cmp_wdata;
    end else if (cap1) begin
      cc1_q <= cnt_q;
    end
  end

  assign capcmp_reg_zero = cc0_q;
  assign capcmp_reg_one = cc1_q;

  ////////////////////////////////////////////////////////////////////////
  // Timer output on the shared pin

  logic tout_q;
  logic match0;

  // Match counted once per count step, not per system clock
  assign match0 = tick & cc0_cmp_mode & (cnt_q == cc0_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tout_q <= 1'b0;
    end else if (!running) begin
      tout_q <= 1'b0;
    end else if (match0) begin
      tout_q <= ~tout_q;
    end
  end

  assign shared_port_pin_out = tout_q;
  assign shared_port_pin_oe = (pin_func_sel == PIN_FUNC_OUTPUT);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_read_tick;
    cnt_rd && tick && !mode_wr;
  endsequence

  sequence s_read_done;
    !cnt_rd && !mode_wr && running;
  endsequence

  a_read_holds_cnt: assert property (
    @(posedge clk_sys) disable iff (rst)
    cnt_rd && running && !mode_wr |=> cnt_q == $past(cnt_q))
    else $error("counter moved during read");

  a_read_no_loss: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_read_tick ##1 s_read_done |=> cnt_q != $past(cnt_q))
    else $error("tick lost across read");

  a_read_no_cap: assert property (
    @(posedge clk_sys) disable iff (rst)
    cnt_rd && !ev1.rise && !cc1_wr |=> $stable(cc1_q))
    else $error("read disturbed register one");

  a_hold_cap_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    !ev0.rise && !cc0_wr |=> $stable(cc0_q))
    else $error("register zero lost its value");

  a_cmp_ignores_cap: assert property (
    @(posedge clk_sys) disable iff (rst)
    cc1_cmp_mode && !cc1_wr |=> $stable(cc1_q))
    else $error("compare register captured");

  a_stop_no_cap: assert property (
    @(posedge clk_sys) disable iff (rst)
    stop_now && !cc0_wr |=> $stable(cc0_q))
    else $error("capture taken on stop");

  // Mode must stay put one cycle later unless a new write arrived
  a_run_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    mode_wr && mode_wfield != MODE_STOP |=>
      running ##1 ($stable(mode_q) || $past(mode_wr)))
    else $error("counter did not start");

  a_stop_clears: assert property (
    @(posedge clk_sys) disable iff (rst)
    stop_now |=> !running ##1 (cnt_q == CNT_RESET || $past(mode_wr)))
    else $error("counter did not stop");

  a_pin_exclusive: assert property (
    @(posedge clk_sys) disable iff (rst)
    shared_port_pin_oe |-> !ev1.rise && !cap1)
    else $error("pin used for both roles");

endmodule : timer_capture_compare_16bit

//--- sim/timer_capture_compare_16bit_tb.sv
// Self-checking bench for the 16-bit capture/compare timer.
// Assumes the design files under hdl/ are compiled before this one.
`timescale 1ns/1ns
module timer_capture_compare_16bit_tb;
  import tcc_pkg::*;
  localparam int PS = 2; // Short prescale keeps the run brief
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mode_wr = 1'b0;
  logic [CTRL_W-1:0] timer_mode_ctrl = '0;
  logic cc0_cmp_mode = 1'b0;
  logic cc1_cmp_mode = 1'b0;
  logic cc0_wr = 1'b0;
  logic cc1_wr = 1'b0;
  logic [COUNT_W-1:0] cmp_wdata = '0;
  logic cnt_rd = 1'b0;
  logic cap0 = 1'b0;
  logic pin_func_sel = 1'b0;
  logic pin_in = 1'b0;
  logic pin_out, pin_oe, running;
  logic [COUNT_W-1:0] cnt, cc0, cc1, v0, v1;
  logic [1:0] fld;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;

  timer_capture_compare_16bit #(.PRESCALE(PS)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .mode_wr(mode_wr),
    .timer_mode_ctrl(timer_mode_ctrl), .cc0_cmp_mode(cc0_cmp_mode),
    .cc1_cmp_mode(cc1_cmp_mode), .cc0_wr(cc0_wr), .cc1_wr(cc1_wr),
    .cmp_wdata(cmp_wdata), .cnt_rd(cnt_rd), .capture_input_zero(cap0),
    .pin_func_sel(pin_func_sel), .shared_port_pin_in(pin_in),
    .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe),
    .up_counter_value(cnt), .capcmp_reg_zero(cc0), .capcmp_reg_one(cc1),
    .running(running));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the full run needs under two hundred cycles
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Expected count after n cycles of free running
  function automatic logic [15:0] after(input logic [15:0] s, input int n);
    return s + 16'(n / PS);
  endfunction : after
  // Cycles after a restart until the output toggles on a match at cmp
  function automatic int tout_wait(input int cmp);
    return PS * (cmp + 1) - 1;
  endfunction : tout_wait
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : step
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check16
  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask : check1
  // One-cycle compare write into register zero or one
  task automatic write_cc(input bit which);
    if (which) cc1_wr = 1'b1;
    else cc0_wr = 1'b1;
    step(1);
    cc0_wr = 1'b0;
    cc1_wr = 1'b0;
    step(1);
  endtask : write_cc
  // Mode write with random filler in the unused low bits
  task automatic set_mode(input logic [1:0] f);
    timer_mode_ctrl = {f, 2'($urandom)};
    mode_wr = 1'b1;
    step(1);
    mode_wr = 1'b0;
    step(1);
  endtask : set_mode
  // Trigger held four cycles, longer than the synchroniser needs
  task automatic pulse(input bit on_pin);
    step($urandom_range(5, 1));
    if (on_pin) pin_in = 1'b1;
    else cap0 = 1'b1;
    step(4);
    pin_in = 1'b0;
    cap0 = 1'b0;
    step(6);
  endtask : pulse
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h695c));
    step(20);
    rst = 1'b0;
    step(1);
    check16(cc0, CC_RESET);
    check1(running, 1'b0);
    $display("test reset done");
    fld = 2'($urandom_range(3, 1));
    set_mode(fld);
    check1(running, 1'b1);
    v0 = cnt;
    step(10);
    check16(cnt, after(v0, 10));
    set_mode(MODE_STOP);
    check1(running, 1'b0);
    v0 = cnt;
    step(5);
    check16(cnt, v0);
    $display("test run stop done");
    set_mode(fld);
    v0 = cnt;
    step(4);
    cnt_rd = 1'b1;
    v1 = cnt;
    step(1);
    check16(cnt, v1);
    cnt_rd = 1'b0;
    step(5);
    check16(cnt, after(v0, 10));
    check16(cc1, CC_RESET);
    $display("test counter read done");
    v0 = cnt;
    pulse(1'b0);
    check1(cc0 >= v0 && cc0 <= cnt, 1'b1);
    v1 = cc0;
    set_mode(MODE_STOP);
    cc0_cmp_mode = 1'b1;
    step(2);
    check16(cc0, v1);
    cmp_wdata = 16'($urandom_range(16'hffff, 16'h0100));
    write_cc(1'b0);
    check16(cc0, cmp_wdata);
    set_mode(fld);
    pulse(1'b0);
    check16(cc0, cmp_wdata);
    $display("test capture zero done");
    // Small compare value so the output toggles within a few steps
    set_mode(MODE_STOP);
    k = $urandom_range(6, 2);
    cmp_wdata = 16'(k);
    write_cc(1'b0);
    pin_func_sel = PIN_FUNC_OUTPUT;
    set_mode(fld);
    step(tout_wait(k) - 1);
    check1(pin_out, 1'b0);
    step(1);
    check1(pin_out, 1'b1);
    set_mode(MODE_STOP);
    check1(pin_out, 1'b0);
    $display("test timer output done");
    pin_func_sel = PIN_FUNC_CAPTURE;
    set_mode(fld);
    check1(pin_oe, 1'b0);
    v0 = cnt;
    pulse(1'b1);
    check1(cc1 >= v0 && cc1 <= cnt && cc1 != CC_RESET, 1'b1);
    v1 = cc1;
    pin_func_sel = PIN_FUNC_OUTPUT;
    step(1);
    check1(pin_oe, 1'b1);
    pulse(1'b1);
    check16(cc1, v1);
    set_mode(MODE_STOP);
    cc1_cmp_mode = 1'b1;
    pin_func_sel = PIN_FUNC_CAPTURE;
    cmp_wdata = 16'($urandom_range(16'hffff, 16'h0100));
    write_cc(1'b1);
    check16(cc1, cmp_wdata);
    set_mode(fld);
    pulse(1'b1);
    check16(cc1, cmp_wdata);
    $display("test shared pin done");
    // Only a device reset may drop a captured or written value
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    check16(cc0, CC_RESET);
    check1(running, 1'b0);
    $display("test reset again done");
    print_verdict();
  end
endmodule : timer_capture_compare_16bit_tb
